// file: logic/oscr_params.svh
/*
 * Constants of the oscillator control register bank: offsets, fields,
 * reset values and timing counts.
 * Assumes a 32-bit Avalon-MM slave, one register per aligned word.
 */
`ifndef OSCR_PARAMS_SVH
`define OSCR_PARAMS_SVH

// byte addresses on the register bus
`define OSCR_OFS_CONTROL 4'h0
`define OSCR_OFS_TUNE_A 4'h4
`define OSCR_OFS_TUNE_B 4'h8
`define OSCR_OFS_SEED 4'hC
`define OSCR_OFS_UNLOCK 4'h0
`define OSCR_OFS_STATUS 4'h0

// unlock: a write of this key to the unlock register arms one write
`define OSCR_ADDR_UNLOCK 4'h0
`define OSCR_UNLOCK_KEY 16'h5A5A

// oscillator_control field positions
`define OSCR_ACT_HI 14
`define OSCR_ACT_LO 12
`define OSCR_REQ_HI 10
`define OSCR_REQ_LO 8
`define OSCR_FREEZE_BIT 7
`define OSCR_PLL_LOCK_BIT 5
`define OSCR_DITHER_BIT 4
`define OSCR_FAIL_BIT 3
`define OSCR_TSEQ_BIT 2
`define OSCR_SWITCH_BIT 0

// other reset values
`define OSCR_TUNE_RESET 16'h0000
`define OSCR_SEED_RESET 15'h0000

// tune sequencer step time and its cycle count at 10 MHz
`define OSCR_STEP_TIME_NS 1000
`define OSCR_CLK_PERIOD_NS 100
`define OSCR_STEP_CYCLES (`OSCR_STEP_TIME_NS / `OSCR_CLK_PERIOD_NS)

`endif

// file: logic/oscr_pkg.sv
/*
 * Types of the oscillator control register bank.
 * Assumes oscr_params.svh is compiled alongside.
 */
package oscr_pkg;

    // clock source codes; 100..111 reserved
    typedef enum logic [2:0] {
        OSCR_SRC_RC = 3'b000,
        OSCR_SRC_RC_PLL = 3'b001,
        OSCR_SRC_PRI = 3'b010,
        OSCR_SRC_PRI_PLL = 3'b011
    } oscr_src_e;

    // avalon-mm request group
    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } oscr_bus_req_s;

    // avalon-mm answer group
    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } oscr_bus_rsp_s;

    // complete state of the register bank
    typedef struct packed {
        logic [2:0] active_source;
        logic [2:0] requested_source;
        logic config_freeze;
        logic dither_enable;
        logic clock_fail_flag;
        logic tune_sequencer_enable;
        logic switch_request;
        logic unlocked;
        logic [15:0] tune_a;
        logic [15:0] tune_b;
        logic [14:0] dither_seed;
        logic [2:0] seq_index;
        logic [7:0] step_cnt;
        logic ack;
        logic [31:0] readdata;
        logic [3:0] rc_trim;
        logic init_done;
    } oscr_state_s;

endpackage

// file: logic/oscr_regs.sv
/*
 * Oscillator control register bank: current and requested clock source,
 * switch request, configuration freeze, PLL lock and clock fail status,
 * dither enable, tune sequencer over eight RC trim values, dither seed.
 * Assumes a synchronous power-on reset on rst_i, configuration values
 * that are stable after power-on, and status inputs from the clock
 * switcher, PLL and fail-safe monitor that come from other clock domains
 * and are synchronised here.
 */
`timescale 1ns/1ps
`include "oscr_params.svh"

// Overview of operation
// - active source is read-only three-bit code
// - active source loads initial configuration at power-on
// - clock failure forces active source to fast RC
// - completed switch copies requested into active source
// - requested source writable, resets to initial configuration
// - software sets switch request, hardware clears it
// - freeze plus config bit blocks clock settings
// - freeze cannot be cleared except by reset
// - PLL lock status bit follows hardware
// - dither enable bit drives dithering, resets zero
// - fail flag set by monitor, software clears only
// - sequencer steps all eight trims when enabled
// - trim codes are signed, 0111 maximum frequency
// - first tune register layout, reset zero
// - second tune register layout, reset zero
// - fifteen-bit seed, bit fifteen reads zero
// - registers reset only by power-on reset
// - control writes need prior unlock each time
// - decode switching and monitor configuration
module oscr_regs
    import oscr_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [2:0] initial_source_config_i,
    input wire logic [1:0] switch_monitor_config_i,
    input wire logic switch_done_i,
    input wire logic clock_fail_i,
    input wire logic pll_locked_i,
    output logic [2:0] requested_source_o,
    output logic switch_start_o,
    output logic switching_enabled_o,
    output logic failsafe_monitor_enable_o,
    output logic settings_frozen_o,
    output logic dither_enable_o,
    output logic [14:0] dither_seed_o,
    output logic signed [3:0] rc_trim_o
);

    localparam logic [7:0] STEP_LAST = 8'(`OSCR_STEP_CYCLES - 1);

    oscr_state_s st_r;
    oscr_state_s st_nxt;
    oscr_bus_req_s req;

    // two-flop synchronisers for the asynchronous status inputs
    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic sw_done_q;
    logic fail_q;
    logic pll_q;
    logic fail_seen_r;
    logic fail_rise;
    logic done_seen_r;
    logic done_rise;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            meta_r <= 3'h0;
            sync_r <= 3'h0;
            fail_seen_r <= 1'b0;
            done_seen_r <= 1'b0;
        end else begin
            meta_r <= {pll_locked_i, clock_fail_i, switch_done_i};
            sync_r <= meta_r;
            fail_seen_r <= sync_r[1];
            done_seen_r <= sync_r[0];
        end
    end

    assign sw_done_q = sync_r[0];
    assign fail_q = sync_r[1];
    assign pll_q = sync_r[2];
    assign fail_rise = fail_q & ~fail_seen_r;
    assign done_rise = sw_done_q & ~done_seen_r;

    // request bundle
    assign req.address = avs_address_i;
    assign req.read = avs_read_i;
    assign req.write = avs_write_i;
    assign req.writedata = avs_writedata_i;

    // configuration decode
    logic sw_enabled;
    logic failsafe_monitor_enabled;
    logic frozen;
    logic src_reserved;
    logic wr_ctl;
    logic [15:0] wd;
    logic [15:0] ctl_view;
    logic [3:0] trims [0:7];

    assign sw_enabled = ~switch_monitor_config_i[1];
    assign failsafe_monitor_enabled = (switch_monitor_config_i == 2'h0);
    // freeze only bites with the upper config bit set
    assign frozen = st_r.config_freeze & switch_monitor_config_i[1];
    assign src_reserved = st_r.requested_source[2];
    assign wd = req.writedata[15:0];

    // a control write needs a fresh unlock; one write per unlock, reads keep it
    assign wr_ctl = req.write & ~st_r.ack & st_r.init_done
        & (req.address == `OSCR_OFS_CONTROL) & st_r.unlocked;

    // control word as software sees it, unimplemented bits zero
    always_comb begin
        ctl_view = 16'h0000;
        ctl_view[`OSCR_ACT_HI:`OSCR_ACT_LO] = st_r.active_source;
        ctl_view[`OSCR_REQ_HI:`OSCR_REQ_LO] = st_r.requested_source;
        ctl_view[`OSCR_FREEZE_BIT] = st_r.config_freeze;
        ctl_view[`OSCR_PLL_LOCK_BIT] = pll_q;
        ctl_view[`OSCR_DITHER_BIT] = st_r.dither_enable;
        ctl_view[`OSCR_FAIL_BIT] = st_r.clock_fail_flag;
        ctl_view[`OSCR_TSEQ_BIT] = st_r.tune_sequencer_enable;
        ctl_view[`OSCR_SWITCH_BIT] = st_r.switch_request;
    end

    // trim table: base then sequence values 1..7
    always_comb begin
        trims[0] = st_r.tune_a[3:0];
        trims[1] = st_r.tune_a[7:4];
        trims[2] = st_r.tune_a[11:8];
        trims[3] = st_r.tune_a[15:12];
        trims[4] = st_r.tune_b[3:0];
        trims[5] = st_r.tune_b[7:4];
        trims[6] = st_r.tune_b[11:8];
        trims[7] = st_r.tune_b[15:12];
    end

    // next-state logic for the whole bank
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;

        // capture straps one cycle after power-on reset release
        if (!st_r.init_done) begin
            st_nxt.init_done = 1'b1;
            st_nxt.active_source = initial_source_config_i;
            st_nxt.requested_source = initial_source_config_i;
        end

        // bus write side; ack answers one cycle after the request
        if ((req.read | req.write) & st_r.init_done & ~st_r.ack) begin
            st_nxt.ack = 1'b1;
        end
        if (req.write & st_r.init_done & ~st_r.ack) begin
            // any bus write consumes the unlock, key write rearms it
            st_nxt.unlocked = (req.address == `OSCR_ADDR_UNLOCK)
                & (req.writedata[31:16] == `OSCR_UNLOCK_KEY);
            unique case (req.address)
                `OSCR_OFS_CONTROL: begin
                    if (wr_ctl) begin
                        if (!frozen) begin
                            st_nxt.requested_source =
                                wd[`OSCR_REQ_HI:`OSCR_REQ_LO];
                            st_nxt.tune_sequencer_enable =
                                wd[`OSCR_TSEQ_BIT];
                            st_nxt.switch_request = st_r.switch_request
                                | wd[`OSCR_SWITCH_BIT];
                        end
                        st_nxt.dither_enable = wd[`OSCR_DITHER_BIT];
                        // set only; a 0 never clears the freeze
                        st_nxt.config_freeze = st_r.config_freeze
                            | wd[`OSCR_FREEZE_BIT];
                        // software may clear only
                        if (!wd[`OSCR_FAIL_BIT]) begin
                            st_nxt.clock_fail_flag = 1'b0;
                        end
                    end
                end
                `OSCR_OFS_TUNE_A: begin
                    if (!frozen) begin
                        st_nxt.tune_a = wd;
                    end
                end
                `OSCR_OFS_TUNE_B: begin
                    if (!frozen) begin
                        st_nxt.tune_b = wd;
                    end
                end
                `OSCR_OFS_SEED: begin
                    st_nxt.dither_seed = wd[14:0];
                end
                default: begin
                end
            endcase
        end

        // switch request handling
        if (st_r.switch_request) begin
            if (src_reserved || !sw_enabled) begin
                st_nxt.switch_request = 1'b0;
            end else if (done_rise) begin
                st_nxt.active_source = st_r.requested_source;
                // a fresh software set in the same cycle beats the clear
                st_nxt.switch_request = wr_ctl & ~frozen
                    & wd[`OSCR_SWITCH_BIT];
            end
        end

        // fail event wins over both a switch and a software clear
        if (fail_rise && failsafe_monitor_enabled) begin
            st_nxt.clock_fail_flag = 1'b1;
            st_nxt.active_source = OSCR_SRC_RC;
            st_nxt.switch_request = 1'b0;
        end

        // tune sequencer: step through eight trims, else hold base
        if (st_r.tune_sequencer_enable) begin
            if (st_r.step_cnt == STEP_LAST) begin
                st_nxt.step_cnt = 8'h00;
                st_nxt.seq_index = st_r.seq_index + 3'h1;
            end else begin
                st_nxt.step_cnt = st_r.step_cnt + 8'h01;
            end
        end else begin
            st_nxt.step_cnt = 8'h00;
            st_nxt.seq_index = 3'h0;
        end
        st_nxt.rc_trim = trims[st_nxt.seq_index];

        // registered read data, zero for unmapped addresses
        st_nxt.readdata = 32'h0000_0000;
        if (req.read & st_r.init_done & ~st_r.ack) begin
            unique case (req.address)
                `OSCR_OFS_CONTROL: st_nxt.readdata = {16'h0000, ctl_view};
                `OSCR_OFS_TUNE_A: st_nxt.readdata = {16'h0000, st_r.tune_a};
                `OSCR_OFS_TUNE_B: st_nxt.readdata = {16'h0000, st_r.tune_b};
                `OSCR_OFS_SEED: begin
                    st_nxt.readdata = {17'h00000, st_r.dither_seed};
                end
                default: st_nxt.readdata = 32'h0000_0000;
            endcase
        end
    end

    // only the power-on reset returns the bank to its reset values
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~st_r.ack;
    assign avs_readdata_o = st_r.readdata;
    assign requested_source_o = st_r.requested_source;
    // valid switch pending; the switcher answers with switch_done_i
    assign switch_start_o = st_r.switch_request & ~src_reserved
        & sw_enabled;
    assign switching_enabled_o = sw_enabled;
    assign failsafe_monitor_enable_o = failsafe_monitor_enabled;
    assign settings_frozen_o = frozen;
    assign dither_enable_o = st_r.dither_enable;
    assign dither_seed_o = st_r.dither_seed;
    assign rc_trim_o = st_r.rc_trim;

endmodule

// file: testbench/oscr_regs_properties.sv
/*
 * Port-level checks of the oscillator register bank.
 * Assumes it is bound to oscr_regs, one clock, synchronous reset.
 */
`timescale 1ns/1ps
module oscr_regs_check (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [1:0] switch_monitor_config_i,
    input wire logic switch_done_i,
    input wire logic [2:0] requested_source_o,
    input wire logic switch_start_o,
    input wire logic switching_enabled_o,
    input wire logic failsafe_monitor_enable_o,
    input wire logic settings_frozen_o,
    input wire logic dither_enable_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    // read data is judged only in the cycle it is accepted
    seed_top_zero_a: assert property (
        avs_read_i && !avs_waitrequest_o && avs_address_i == 4'hC
        |-> avs_readdata_o[31:15] == 17'h0)
        else $error("seed read shows bits above 14");
    ctrl_unused_zero_a: assert property (
        avs_read_i && !avs_waitrequest_o && avs_address_i == 4'h0
        |-> {avs_readdata_o[15], avs_readdata_o[11],
        avs_readdata_o[6], avs_readdata_o[1]} == 4'h0)
        else $error("unused control bit reads one");
    unfrozen_cfg_a: assert property (
        !switch_monitor_config_i[1] |-> !settings_frozen_o)
        else $error("frozen with config high bit clear");
    switch_decode_a: assert property (
        switching_enabled_o == !switch_monitor_config_i[1])
        else $error("switch enable decode wrong");
    monitor_decode_a: assert property (
        failsafe_monitor_enable_o == (switch_monitor_config_i == 2'h0))
        else $error("monitor enable decode wrong");
    start_valid_a: assert property (
        switch_start_o |-> !requested_source_o[2] && switching_enabled_o)
        else $error("switch started on reserved or disabled");
    freeze_sticky_a: assert property (settings_frozen_o &&
        $stable(switch_monitor_config_i) |=> settings_frozen_o)
        else $error("freeze dropped without reset");
    dither_cause_a: assert property ($changed(dither_enable_o) |->
        $past(avs_write_i) && $past(avs_address_i) == 4'h0)
        else $error("dither enable moved without control write");
    switch_end_a: assert property ($rose(switch_done_i) &&
        switch_start_o |-> ##[1:6] !switch_start_o)
        else $error("switch request not cleared after completion");
endmodule

bind oscr_regs oscr_regs_check u_chk (.mclk_i(mclk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .switch_monitor_config_i(switch_monitor_config_i),
    .switch_done_i(switch_done_i), .requested_source_o(requested_source_o),
    .switch_start_o(switch_start_o), .switching_enabled_o(switching_enabled_o),
    .failsafe_monitor_enable_o(failsafe_monitor_enable_o),
    .settings_frozen_o(settings_frozen_o), .dither_enable_o(dither_enable_o));

// file: testbench/test_oscillator_control_registers.sv
/*
 * Self-checking bench of the oscillator register bank.
 * Assumes oscr_regs, its package and the bound checker are compiled.
 */
`timescale 1ns/1ps
`include "oscr_params.svh"
module test_oscillator_control_registers
    import oscr_pkg::*;
;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o, q;
    logic avs_waitrequest_o, switch_start_o, switching_enabled_o;
    logic failsafe_monitor_enable_o, settings_frozen_o, dither_enable_o;
    logic [2:0] initial_source_config_i = 3'h2;
    logic [2:0] requested_source_o;
    logic [1:0] switch_monitor_config_i = 2'h0;
    logic switch_done_i = 1'b0;
    logic clock_fail_i = 1'b0;
    logic pll_locked_i = 1'b0;
    logic [14:0] dither_seed_o;
    logic signed [3:0] rc_trim_o;
    int n_errors = 0;
    int checks = 0;

    // 10 MHz clock
    always #50 mclk_i = ~mclk_i;

    oscr_regs dut (.mclk_i(mclk_i), .rst_i(rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .initial_source_config_i(initial_source_config_i),
        .switch_monitor_config_i(switch_monitor_config_i),
        .switch_done_i(switch_done_i), .clock_fail_i(clock_fail_i),
        .pll_locked_i(pll_locked_i), .requested_source_o(requested_source_o),
        .switch_start_o(switch_start_o),
        .switching_enabled_o(switching_enabled_o),
        .failsafe_monitor_enable_o(failsafe_monitor_enable_o),
        .settings_frozen_o(settings_frozen_o),
        .dither_enable_o(dither_enable_o), .dither_seed_o(dither_seed_o),
        .rc_trim_o(rc_trim_o));

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one bus access; request held until the edge that sees waitrequest
    // low, read data taken at that same edge, then released
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_read_i <= !w;
        avs_write_i <= w;
        do begin
            @(posedge mclk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (n >= 50) chk("bus answer", 32'h0, 32'h1);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e,
        input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask

    // unlock then control write; the key write alone is refused
    task automatic cw(input logic [15:0] d);
        bus(1'b1, 4'h0, {`OSCR_UNLOCK_KEY, d});
        bus(1'b1, 4'h0, {16'h0, d});
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask

    task automatic t_reset;
        rd(4'h0, 32'h2200, "ctrl reset");
        rd(4'h4, 32'h0, "tune a reset");
        rd(4'h8, 32'h0, "tune b reset");
        rd(4'hC, 32'h0, "seed reset");
        chk("monitor on", failsafe_monitor_enable_o, 32'h1);
    endtask

    task automatic t_lock;
        bus(1'b1, 4'h0, 32'h10);
        rd(4'h0, 32'h2200, "locked ctrl");
        cw(16'h8A52);
        rd(4'h0, 32'h2210, "unlocked ctrl");
        wait_n(1);
        chk("dither out", dither_enable_o, 32'h1);
    endtask

    task automatic t_tune;
        bus(1'b1, 4'h4, 32'h3218);
        bus(1'b1, 4'h8, 32'h7654);
        bus(1'b1, 4'hC, 32'hFFFF);
        rd(4'h4, 32'h3218, "tune a");
        rd(4'h8, 32'h7654, "tune b");
        rd(4'hC, 32'h7FFF, "seed");
        rd(4'h2, 32'h0, "unmapped");
        wait_n(1);
        chk("seed out", dither_seed_o, 32'h7FFF);
        chk("base trim", {rc_trim_o}, 32'h8);
        chk("trim sign", rc_trim_o < 0, 32'h1);
    endtask

    // trims hold 8,1..7 so the value names its sequence slot
    task automatic t_seq;
        int n;
        int idx;
        logic [3:0] v;
        cw(16'h0214);
        n = 0;
        v = rc_trim_o;
        do begin
            @(negedge mclk_i);
            n++;
        end while (rc_trim_o === v && n < 30);
        idx = (rc_trim_o == 4'h8) ? 0 : int'(rc_trim_o);
        repeat (5) @(negedge mclk_i);
        for (int k = 0; k < 8; k++) begin
            repeat (`OSCR_STEP_CYCLES) @(negedge mclk_i);
            idx = (idx + 1) % 8;
            chk("sequenced trim", {rc_trim_o}, idx == 0 ? 8 : idx);
        end
        cw(16'h0210);
        wait_n(2);
        chk("trim after stop", {rc_trim_o}, 32'h8);
    endtask

    task automatic t_switch;
        cw(16'h0311);
        wait_n(1);
        chk("switch start", switch_start_o, 32'h1);
        chk("requested out", requested_source_o, 32'h3);
        @(posedge mclk_i);
        switch_done_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        switch_done_i <= 1'b0;
        rd(4'h0, 32'h3310, "switched");
        cw(16'h0511);
        wait_n(3);
        chk("reserved start", switch_start_o, 32'h0);
        rd(4'h0, 32'h3510, "reserved ctrl");
    endtask

    task automatic t_fail;
        @(posedge mclk_i);
        pll_locked_i <= 1'b1;
        clock_fail_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        clock_fail_i <= 1'b0;
        rd(4'h0, 32'h0538, "failed");
        cw(16'h0510);
        rd(4'h0, 32'h0530, "fail cleared");
        cw(16'h0518);
        rd(4'h0, 32'h0530, "fail not set");
    endtask

    task automatic t_freeze;
        @(posedge mclk_i);
        switch_monitor_config_i <= 2'h2;
        wait_n(1);
        chk("switch enable", switching_enabled_o, 32'h0);
        chk("monitor enable", failsafe_monitor_enable_o, 32'h0);
        cw(16'h0590);
        wait_n(1);
        chk("frozen", settings_frozen_o, 32'h1);
        bus(1'b1, 4'h4, 32'h0);
        rd(4'h4, 32'h3218, "frozen tune");
        cw(16'h0211);
        rd(4'h0, 32'h05B0, "freeze kept");
    endtask

    // mid-run power-on reset clears the freeze and returns every register to its reset value
    task automatic t_por;
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rd(4'h0, 32'h2220, "ctrl after reset");
        rd(4'h4, 32'h0, "tune a after reset");
        rd(4'h8, 32'h0, "tune b after reset");
        rd(4'hC, 32'h0, "seed after reset");
        chk("freeze after reset", settings_frozen_o, 32'h0);
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // watchdog well past the few hundred cycles the tests need
    initial begin
        #400000;
        n_errors++;
        print_verdict;
    end

    initial begin
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        t_reset;
        t_lock;
        t_tune;
        t_seq;
        t_switch;
        t_fail;
        t_freeze;
        t_por;
        print_verdict;
    end
endmodule
